// ===== sfp_cmd.sv
// Module: command decode for write disable, status write with lock, and id read
`timescale 1ns/1ps

// Function
// - Write disable clears the write enable latch and the auto increment flag.
// - Write disable takes effect only at the chip select rising edge.
// - Status write enable arms the next status write command.
// - Any command after the enable other than an enable command drops the arming.
// - Permitted status write loads both protect bits and lock from data.
// - Status write is accepted only directly after an enabling command.
// - Status write ignored while protect pin low and lock set.
// - Protect pin high disables the lock; all three bits writable.
// - Permission uses lock and pin level sampled after the ending edge.
// - Id read shifts out manufacturer byte then two device bytes.
// - Device bytes go out memory type first, then capacity.
// - Chip select high ends id output at once and releases output.
// - Opcode 04h decodes as write disable, ending auto increment.
// - Either enable command arms status write; success clears the latch.
module sfp_cmd #(
    parameter logic [7:0] OP_STATUS_WR_EN = 8'h50,
    parameter logic [7:0] OP_STATUS_WR    = 8'h01,
    parameter logic [7:0] OP_WRITE_EN     = 8'h06,
    parameter logic [7:0] OP_ID_READ      = 8'h9F,
    // Identification bytes; values are arbitrary
    parameter logic [7:0] MFR_CODE        = 8'h5A,
    parameter logic [7:0] MEM_TYPE        = 8'h21,
    parameter logic [7:0] MEM_CAP         = 8'h13
) (
    // System
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Serial link
    input  wire logic                  sck,
    input  wire logic                  cs_n,
    input  wire logic                  mosi,
    output logic                       so,
    output logic                       so_oe,
    // Pins and neighbouring logic
    input  wire logic                  write_protect_n,
    input  wire logic                  aai_set,
    // Status
    output sfp_pkg::sfp_status_t       status,
    output logic                       status_write_armed
);

    sfp_pkg::sfp_shift_t sh_q;
    sfp_pkg::sfp_shift_t sh_d;
    sfp_pkg::sfp_frame_t fr_q;
    sfp_pkg::sfp_frame_t fr_d;
    sfp_pkg::sfp_out_t   out_q;
    sfp_pkg::sfp_out_t   out_d;
    sfp_pkg::sfp_ctl_t   ctl_q;
    sfp_pkg::sfp_ctl_t   ctl_d;

    logic                link_rst;
    logic [23:0]         id_word;
    logic [7:0]          rx_byte;
    logic                cs_rise;
    logic                commit;
    logic                full_op;
    logic                wr_ok;

    assign link_rst = ctl_q.rst;
    assign id_word  = {MFR_CODE, MEM_TYPE, MEM_CAP};
    assign rx_byte  = {sh_q.sh, mosi};

    // ---------------- Link domain, serial clock ----------------

    // Bit counter and shifter restart with every frame
    always_comb begin
        sh_d    = sh_q;
        sh_d.sh = rx_byte[6:0];
        if (sh_q.cnt != sfp_pkg::CNT_MAX) begin
            sh_d.cnt = sh_q.cnt + sfp_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge sck or posedge cs_n or posedge link_rst) begin
        if (link_rst || cs_n) begin
            sh_q <= sfp_pkg::RST_SHIFT;
        end else begin
            sh_q <= sh_d;
        end
    end

    // Frame record survives the chip select rise so the system side can read it
    always_comb begin
        fr_d = fr_q;
        if (sh_q.cnt == '0) begin
            fr_d.tog = ~fr_q.tog;
        end
        if (sh_q.cnt < sfp_pkg::CNT_FULL) begin
            fr_d.bits = sh_q.cnt + sfp_pkg::CNT_ONE;
        end
        if (sh_q.cnt == sfp_pkg::CNT_OP_LAST) begin
            fr_d.op = rx_byte;
        end
        if (sh_q.cnt == sfp_pkg::CNT_DATA_LAST) begin
            fr_d.data = rx_byte;
        end
    end

    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            fr_q <= sfp_pkg::RST_FRAME;
        end else begin
            fr_q <= fr_d;
        end
    end

    // Id bytes leave on the falling edge, most significant bit first
    always_comb begin
        out_d.so = 1'b0;
        out_d.oe = 1'b0;
        if ((fr_q.op == OP_ID_READ) && (sh_q.cnt >= sfp_pkg::CNT_ID_FIRST)) begin
            out_d.oe = 1'b1;
            // Past the third byte the pin stays driven low
            if (sh_q.cnt < sfp_pkg::CNT_ID_END) begin
                out_d.so = id_word[5'(sfp_pkg::CNT_ID_LAST - sh_q.cnt)];
            end
        end
    end

    // Chip select high releases the pin without waiting for a clock edge
    always_ff @(negedge sck or posedge cs_n or posedge link_rst) begin
        if (link_rst || cs_n) begin
            out_q <= sfp_pkg::RST_OUT;
        end else begin
            out_q <= out_d;
        end
    end

    assign so    = out_q.so;
    assign so_oe = out_q.oe;

    // ---------------- System domain ----------------

    // The frame record is quiet once chip select is high, so it is read only on the synchronised rise
    assign cs_rise = ctl_q.cs_s & ~ctl_q.cs_p;
    assign commit  = cs_rise & (fr_q.tog != ctl_q.seen_tog);
    assign full_op = fr_q.bits >= sfp_pkg::CNT_OP_BITS;
    assign wr_ok   = ctl_q.armed & (fr_q.bits == sfp_pkg::CNT_FULL)
                   & (~ctl_q.st.lock | ctl_q.wp_s);

    always_comb begin
        ctl_d      = ctl_q;
        ctl_d.rst  = sys_rst;
        ctl_d.cs_m = cs_n;
        ctl_d.cs_s = ctl_q.cs_m;
        ctl_d.cs_p = ctl_q.cs_s;
        ctl_d.wp_m = write_protect_n;
        ctl_d.wp_s = ctl_q.wp_m;
        if (cs_rise) begin
            ctl_d.seen_tog = fr_q.tog;
        end
        if (commit && full_op) begin
            ctl_d.armed = 1'b0;
            if (fr_q.op == sfp_pkg::OP_WRITE_DISABLE) begin
                ctl_d.st.write_enable_latch = 1'b0;
                ctl_d.st.auto_increment_program = 1'b0;
            end else if (fr_q.op == OP_STATUS_WR_EN) begin
                ctl_d.armed = 1'b1;
            end else if (fr_q.op == OP_WRITE_EN) begin
                ctl_d.st.write_enable_latch = 1'b1;
                ctl_d.armed  = 1'b1;
            end else if ((fr_q.op == OP_STATUS_WR) && wr_ok) begin
                ctl_d.st.bp0  = fr_q.data[sfp_pkg::POS_BP0];
                ctl_d.st.bp1  = fr_q.data[sfp_pkg::POS_BP1];
                ctl_d.st.lock = fr_q.data[sfp_pkg::POS_LOCK];
                ctl_d.st.write_enable_latch  = 1'b0;
            end
        end
        // A start from the neighbouring program logic wins over a same-cycle clear
        if (aai_set) begin
            ctl_d.st.auto_increment_program = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_q <= sfp_pkg::RST_CTL;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign status             = ctl_q.st;
    assign status_write_armed = ctl_q.armed;

    // ---------------- Checks ----------------

    sequence s_enable_frame;
        commit && full_op && ((fr_q.op == OP_STATUS_WR_EN) || (fr_q.op == OP_WRITE_EN));
    endsequence

    sequence s_write_frame;
        commit && full_op && (fr_q.op == OP_STATUS_WR);
    endsequence

    sequence s_good_write;
        s_write_frame and (wr_ok && !aai_set);
    endsequence

    a_disable_clears: assert property (@(posedge clk) disable iff (sys_rst)
        (commit && full_op && (fr_q.op == sfp_pkg::OP_WRITE_DISABLE) && !aai_set)
        |=> (!status.write_enable_latch && !status.auto_increment_program))
        else $error("write disable left latch or auto increment set");

    a_frame_only_edge: assert property (@(posedge clk) disable iff (sys_rst)
        (!commit) |=> ($stable(status.write_enable_latch) && $stable(status.lock)
                       && $stable(status.bp0) && $stable(status.bp1)))
        else $error("status changed without a chip select rise");

    a_enable_arms: assert property (@(posedge clk) disable iff (sys_rst)
        s_enable_frame |=> status_write_armed)
        else $error("enable command did not arm status write");

    a_arm_dropped: assert property (@(posedge clk) disable iff (sys_rst)
        (commit && full_op && (fr_q.op != OP_STATUS_WR_EN) && (fr_q.op != OP_WRITE_EN))
        |=> !status_write_armed)
        else $error("arming survived another command");

    a_write_loads: assert property (@(posedge clk) disable iff (sys_rst)
        s_good_write |=> ((status.bp0 == $past(fr_q.data[sfp_pkg::POS_BP0]))
                          && (status.bp1 == $past(fr_q.data[sfp_pkg::POS_BP1]))
                          && (status.lock == $past(fr_q.data[sfp_pkg::POS_LOCK]))
                          && !status.write_enable_latch))
        else $error("permitted status write did not load");

    a_write_unarmed: assert property (@(posedge clk) disable iff (sys_rst)
        (s_write_frame and !status_write_armed)
        |=> ($stable(status.lock) && $stable(status.bp0) && $stable(status.bp1)))
        else $error("status write accepted without arming");

    a_lock_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (s_write_frame and (status.lock && !ctl_q.wp_s))
        |=> (status.lock && $stable(status.bp0) && $stable(status.bp1) && !status_write_armed))
        else $error("locked status register was changed");

    a_pin_unlocks: assert property (@(posedge clk) disable iff (sys_rst)
        (s_write_frame and (status_write_armed && ctl_q.wp_s && (fr_q.bits == sfp_pkg::CNT_FULL)))
        |=> (status.lock == $past(fr_q.data[sfp_pkg::POS_LOCK])))
        else $error("protect pin high did not unlock");

    a_partial_ignored: assert property (@(posedge clk) disable iff (sys_rst)
        (commit && !full_op) |=> ($stable(status_write_armed) && $stable(status.write_enable_latch)
                                  && $stable(status.lock)))
        else $error("partial opcode frame had an effect");

    a_output_release: assert property (@(posedge clk) disable iff (sys_rst)
        (ctl_q.cs_s && ctl_q.cs_p) |-> !so_oe)
        else $error("serial output driven with chip select high");

    a_id_order: assert property (@(posedge sck) disable iff (cs_n || link_rst)
        ((fr_q.op == OP_ID_READ) && (sh_q.cnt == sfp_pkg::CNT_ID_FIRST))
        ##8 (sh_q.cnt == sfp_pkg::CNT_ID_TYPE) |-> (so_oe && (so == MEM_TYPE[7])))
        else $error("memory type byte not second");

    a_id_cap: assert property (@(posedge sck) disable iff (cs_n || link_rst)
        ((fr_q.op == OP_ID_READ) && (sh_q.cnt == sfp_pkg::CNT_ID_CAP))
        |-> (so_oe && (so == MEM_CAP[7]) && ($past(so, 16) == MFR_CODE[7])))
        else $error("capacity byte not third");

    // Each check below but a_cs_release pins one path by which a status bit may move
    sequence s_open_write;
        s_write_frame and (status_write_armed && !status.lock && (fr_q.bits == sfp_pkg::CNT_FULL));
    endsequence

    sequence s_id_start;
        (fr_q.op == OP_ID_READ) && (sh_q.cnt == sfp_pkg::CNT_ID_FIRST);
    endsequence

    a_open_lock: assert property (@(posedge clk) disable iff (sys_rst)
        s_open_write |=> ((status.lock == $past(fr_q.data[sfp_pkg::POS_LOCK]))
                          && (status.bp1 == $past(fr_q.data[sfp_pkg::POS_BP1]))
                          && (status.bp0 == $past(fr_q.data[sfp_pkg::POS_BP0]))))
        else $error("unlocked status write was refused");

    a_lock_in_one: assert property (@(posedge clk) disable iff (sys_rst)
        (s_good_write and fr_q.data[sfp_pkg::POS_LOCK])
        |=> (status.lock && (status.bp1 == $past(fr_q.data[sfp_pkg::POS_BP1]))
             && (status.bp0 == $past(fr_q.data[sfp_pkg::POS_BP0]))))
        else $error("lock and protect bits not set together");

    a_pin_relock: assert property (@(posedge clk) disable iff (sys_rst)
        (s_write_frame and (status_write_armed && status.lock && ctl_q.wp_s
                            && (fr_q.bits == sfp_pkg::CNT_FULL)))
        |=> ((status.bp1 == $past(fr_q.data[sfp_pkg::POS_BP1]))
             && (status.bp0 == $past(fr_q.data[sfp_pkg::POS_BP0]))))
        else $error("locked register not writable with pin high");

    // Catches any path besides a permitted write that moves the protect bits
    a_status_source: assert property (@(posedge clk) disable iff (sys_rst)
        !$stable({status.lock, status.bp1, status.bp0})
        |-> $past(commit && full_op && wr_ok && (fr_q.op == OP_STATUS_WR)))
        else $error("protect bits changed without a permitted write");

    a_arm_source: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(status_write_armed)
        |-> $past(commit && full_op && ((fr_q.op == OP_STATUS_WR_EN) || (fr_q.op == OP_WRITE_EN))))
        else $error("status write armed without an enable command");

    a_latch_source: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(status.write_enable_latch) |-> $past(commit && full_op && (fr_q.op == OP_WRITE_EN)))
        else $error("write enable latch set without its command");

    a_wen_arms: assert property (@(posedge clk) disable iff (sys_rst)
        (commit && full_op && (fr_q.op == OP_WRITE_EN)) |=> (status.write_enable_latch && status_write_armed))
        else $error("write enable did not set latch and arming");

    a_latch_fall: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(status.write_enable_latch) |-> $past(commit))
        else $error("latch cleared without a chip select rise");

    a_short_write: assert property (@(posedge clk) disable iff (sys_rst)
        (s_write_frame and (fr_q.bits != sfp_pkg::CNT_FULL))
        |=> ($stable(status.lock) && $stable(status.bp1) && $stable(status.bp0) && !status_write_armed))
        else $error("short status write had an effect");

    a_disable_disarms: assert property (@(posedge clk) disable iff (sys_rst)
        (commit && full_op && (fr_q.op == sfp_pkg::OP_WRITE_DISABLE)) |=> !status_write_armed)
        else $error("write disable left status write armed");

    a_aai_wins: assert property (@(posedge clk) disable iff (sys_rst)
        aai_set |=> status.auto_increment_program)
        else $error("program start did not set auto increment flag");

    a_partial_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        (commit && !full_op && !aai_set)
        |=> ($stable(status.auto_increment_program) && $stable(status.bp0) && $stable(status.bp1)))
        else $error("partial opcode frame moved a status bit");

    a_cs_release: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(ctl_q.cs_m) |-> !so_oe)
        else $error("serial output still driven after chip select rise");

    // Link side checks sample on the serial clock; chip select high cuts them off
    a_id_first: assert property (@(posedge sck) disable iff (cs_n || link_rst)
        s_id_start |-> (so_oe && (so == MFR_CODE[7])))
        else $error("manufacturer byte not first");

    a_id_driven: assert property (@(posedge sck) disable iff (cs_n || link_rst)
        ((fr_q.op == OP_ID_READ) && (sh_q.cnt > sfp_pkg::CNT_ID_FIRST)) |-> so_oe)
        else $error("id output released early");

    a_id_silent: assert property (@(posedge sck) disable iff (cs_n || link_rst)
        ((fr_q.op != OP_ID_READ) && (sh_q.cnt >= sfp_pkg::CNT_ID_FIRST)) |-> !so_oe)
        else $error("serial output driven outside id read");

endmodule

// ===== sfp_pkg.sv
// Package: constants and carriers for the serial flash status, protect and id command slice
package sfp_pkg;

    // Opcode fixed by the command set
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

    // Link bit counter width and milestones
    localparam int         CNT_W         = 6;
    localparam logic [5:0] CNT_OP_LAST   = 6'h07;
    localparam logic [5:0] CNT_OP_BITS   = 6'h08;
    localparam logic [5:0] CNT_DATA_LAST = 6'h0F;
    localparam logic [5:0] CNT_FULL      = 6'h10;
    localparam logic [5:0] CNT_ID_FIRST  = 6'h08;
    localparam logic [5:0] CNT_ID_TYPE   = 6'h10;
    localparam logic [5:0] CNT_ID_CAP    = 6'h18;
    localparam logic [5:0] CNT_ID_LAST   = 6'h1F;
    localparam logic [5:0] CNT_ID_END    = 6'h20;
    localparam logic [5:0] CNT_ONE       = 6'h01;
    localparam logic [5:0] CNT_MAX       = 6'h3F;

    // Field positions in the status write data byte
    localparam int POS_BP0  = 2;
    localparam int POS_BP1  = 3;
    localparam int POS_LOCK = 7;

    // Host power-up wait before the first command, in microseconds
    localparam int T_PWRUP_US = 10;

    typedef struct packed {
        logic lock;
        logic bp1;
        logic bp0;
        logic auto_increment_program;
        logic write_enable_latch;
    } sfp_status_t;

    typedef struct packed {
        logic [5:0] cnt;
        logic [6:0] sh;
    } sfp_shift_t;

    typedef struct packed {
        logic       tog;
        logic [5:0] bits;
        logic [7:0] op;
        logic [7:0] data;
    } sfp_frame_t;

    typedef struct packed {
        logic        so;
        logic        oe;
    } sfp_out_t;

    typedef struct packed {
        logic        rst;
        logic        cs_m;
        logic        cs_s;
        logic        cs_p;
        logic        wp_m;
        logic        wp_s;
        logic        seen_tog;
        logic        armed;
        sfp_status_t st;
    } sfp_ctl_t;

    localparam sfp_status_t RST_STATUS = '0;
    localparam sfp_shift_t  RST_SHIFT  = '0;
    localparam sfp_frame_t  RST_FRAME  = '0;
    localparam sfp_out_t    RST_OUT    = '0;
    localparam sfp_ctl_t    RST_CTL    = '{rst: 1'b1, cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1,
                                           wp_m: 1'b1, wp_s: 1'b1, seen_tog: 1'b0,
                                           armed: 1'b0, st: RST_STATUS};

endpackage

// ===== sfp_cmd_dummy_guard.sv
// Empty unit: the command slice logic is all in sfp_cmd.sv

// ===== sfp_host_model.sv
// SPI host model that frames mode 0 commands towards the flash command slice
`timescale 1ns/1ps
module sfp_host_model (
    // Link towards the device
    output logic      sck,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic so,
    input  wire logic so_oe
);
    logic [31:0] rx;

    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        rx   = 32'h0000_0000;
    end

    // Sends the low n bits MSB first and leaves chip select low
    task automatic send(input logic [31:0] bits, input int n);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = bits[i];
            #6 sck = 1'b1;
            // A released output reads as the inverse, so a missing enable corrupts the byte
            rx = {rx[30:0], so_oe ? so : ~so};
            #6 sck = 1'b0;
        end
    endtask

    // Raising chip select commits; released data line must not look stable
    task automatic close();
        #6 cs_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the flash status, protect and id command slice
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] SWE = 8'h50;
    localparam logic [7:0] SWR = 8'h01;
    localparam logic [7:0] WEN = 8'h06;
    localparam logic [7:0] IDR = 8'h9F;
    // Id values are arbitrary
    localparam logic [7:0] MFR = 8'hA7;
    localparam logic [7:0] TYP = 8'h3C;
    localparam logic [7:0] CAP = 8'h15;

    logic                 clk;
    logic                 sys_rst;
    logic                 sck;
    logic                 cs_n;
    logic                 mosi;
    logic                 so;
    logic                 so_oe;
    logic                 write_protect_n;
    logic                 aai_set;
    sfp_pkg::sfp_status_t status;
    logic                 status_write_armed;
    int                   error_cnt;
    int                   n_checks;
    int                   cyc;
    integer               seed;
    logic [5:0]           exp_q[$];
    logic                 lock, bp1, bp0, auto_increment_program, write_enable_latch, armed;
    logic [7:0]           dat;
    event                 look;

    sfp_cmd #(.OP_STATUS_WR_EN(SWE), .OP_STATUS_WR(SWR), .OP_WRITE_EN(WEN), .OP_ID_READ(IDR),
              .MFR_CODE(MFR), .MEM_TYPE(TYP), .MEM_CAP(CAP)) dut (
        .clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .so(so),
        .so_oe(so_oe), .write_protect_n(write_protect_n), .aai_set(aai_set),
        .status(status), .status_write_armed(status_write_armed));

    sfp_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .so(so), .so_oe(so_oe));

    always #4 clk = ~clk;

    task automatic tally(input logic ok, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (!ok) begin
            error_cnt++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_st(input logic [5:0] e, input logic [5:0] g);
        tally(g === e, 24'(e), 24'(g));
    endtask
    task automatic cmp_out(input logic [23:0] e, input logic [23:0] g);
        tally(g === e, e, g);
    endtask

    task automatic print_verdict();
        $display("Checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Commit takes 2..3 clk after chip select rises, so 8 is settled
    task automatic note_exp();
        repeat (8) @(posedge clk);
        exp_q.push_back({lock, bp1, bp0, auto_increment_program, write_enable_latch, armed});
        @(negedge clk);
        -> look;
    endtask
    always @(look) cmp_st(exp_q.pop_front(), {status, status_write_armed});

    task automatic cmd(input logic [31:0] b, input int n);
        host.send(b, n);
        host.close();
        note_exp();
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        write_protect_n = 1'b1;
        aai_set = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        cyc = 0;
        seed = 32'h5dd8;
        {lock, bp1, bp0, auto_increment_program, write_enable_latch, armed} = 6'h00;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (sfp_pkg::T_PWRUP_US * 125) @(negedge clk);
        note_exp();
        aai_set = 1'b1;
        @(negedge clk);
        aai_set = 1'b0;
        {auto_increment_program, write_enable_latch, armed} = 3'b111;
        cmd(32'(WEN), 8);
        // Opcode fully shifted but chip select still low: nothing may change yet
        host.send(32'(sfp_pkg::OP_WRITE_DISABLE), 8);
        note_exp();
        host.close();
        {auto_increment_program, write_enable_latch, armed} = 3'b000;
        note_exp();
        armed = 1'b1;
        cmd(32'(SWE), 8);
        cmd(32'h0000_0015, 5);
        for (int i = 0; i < 8; i++) begin
            dat = 8'($random(seed)) | ((i == 1) ? 8'h80 : 8'h00);
            write_protect_n = (i < 2) | i[0];
            armed = 1'b1;
            cmd(32'(SWE), 8);
            if (!lock || write_protect_n)
                {lock, bp1, bp0} = {dat[sfp_pkg::POS_LOCK], dat[sfp_pkg::POS_BP1], dat[sfp_pkg::POS_BP0]};
            armed = 1'b0;
            cmd({16'h0000, SWR, dat}, 16);
        end
        write_protect_n = 1'b1;
        armed = 1'b1;
        cmd(32'(SWE), 8);
        armed = 1'b0;
        cmd(32'(sfp_pkg::OP_WRITE_DISABLE), 8);
        cmd({16'h0000, SWR, ~{lock, 3'b000, bp1, bp0, 2'b00}}, 16);
        armed = 1'b1;
        cmd(32'(SWE), 8);
        armed = 1'b0;
        cmd({20'h0_0000, SWR, 4'hF}, 12);
        {write_enable_latch, armed} = 2'b11;
        cmd(32'(WEN), 8);
        {lock, bp1, bp0, write_enable_latch, armed} = 5'b01100;
        cmd({16'h0000, SWR, 8'h0C}, 16);
        armed = 1'b1;
        cmd(32'(SWE), 8);
        armed = 1'b0;
        host.send({IDR, MFR, TYP, CAP}, 32);
        cmp_out({MFR, TYP, CAP}, host.rx[23:0]);
        cmp_out(24'h00_0001, 24'(so_oe));
        host.close();
        #1 cmp_out(24'h00_0000, 24'({so_oe, so}));
        note_exp();
        host.send({16'h0000, IDR, 8'h00}, 16);
        cmp_out(24'(MFR), 24'(host.rx[7:0]));
        host.close();
        #1 cmp_out(24'h00_0000, 24'({so_oe, so}));
        note_exp();
        print_verdict();
    end
endmodule
